// ===== cmpsvd_ctrl.sv
/*
  Comparator and supply detector control: AXI4-Lite register slave, control
  bits driving the analog blocks, synchroniser and result latches.
  Assumes analog comparator and detector outputs arrive as asynchronous
  levels and that software observes the settle and on-time waits.
*/
`timescale 1ns/1ps
`default_nettype none
module cmpsvd_ctrl
  import cmpsvd_pkg::*;
#(
  parameter bit EXT_SENSE = 1'b0
)
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  s_axi_awvalid,
  output var  logic                  s_axi_awready,
  input  wire logic [BUS_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]            s_axi_awprot,
  input  wire logic                  s_axi_wvalid,
  output var  logic                  s_axi_wready,
  input  wire logic [DATA_W-1:0]     s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  output var  logic                  s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  output var  logic [1:0]            s_axi_bresp,
  input  wire logic                  s_axi_arvalid,
  output var  logic                  s_axi_arready,
  input  wire logic [BUS_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]            s_axi_arprot,
  output var  logic                  s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output var  logic [DATA_W-1:0]     s_axi_rdata,
  output var  logic [1:0]            s_axi_rresp,
  input  wire logic                  comparator_out,
  input  wire logic                  detector_low_out,
  output var  logic                  comparator_power_on,
  output var  logic                  detector_enable,
  output var  logic [2:0]            threshold_select,
  output var  logic                  sense_pin_select
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  cmpsvd_ctrl_t ctrl;
  cmpsvd_ctrl_t next_ctrl;
  cmpsvd_stat_t stat;
  logic         sense_sel;
  logic         next_sense_sel;

  logic aw_held;
  logic next_aw_held;
  logic [BUS_ADDR_W-1:0] aw_addr;
  logic [BUS_ADDR_W-1:0] next_aw_addr;
  logic w_held;
  logic next_w_held;
  logic [DATA_W-1:0] w_data;
  logic [DATA_W-1:0] next_w_data;
  logic [3:0] w_strb;
  logic [3:0] next_w_strb;
  logic bvalid;
  logic next_bvalid;
  logic [1:0] bresp;
  logic [1:0] next_bresp;
  logic rvalid;
  logic next_rvalid;
  logic [DATA_W-1:0] rdata;
  logic [DATA_W-1:0] next_rdata;
  logic [1:0] rresp;
  logic [1:0] next_rresp;

  logic wr_fire;
  logic det_capture;
  logic cmp_sync;
  logic det_sync;
  logic cmp_result;
  logic low_v_result;
  logic aw_ready;
  logic next_aw_ready;
  logic w_ready;
  logic next_w_ready;
  logic ar_ready;
  logic next_ar_ready;

  ////////////////////////////////////////////////////////////////////////////
  // Elaboration checks
  if (THR_LSB + THR_W > 4) begin : g_thr_fit
    $error("threshold field exceeds the four register bits");
  end
  if (CMP_PWR_BIT > 3 || CMP_RES_BIT > 3 || LOW_V_BIT > 3 || DET_EN_BIT > 3) begin : g_bit_fit
    $error("control bit position exceeds the four register bits");
  end
  if (BUS_ADDR_W < 18) begin : g_addr_fit
    $error("bus address too narrow for the register map");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog synchronisers
  // two stage sync
  cmpsvd_sync u_cmp_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (comparator_out),
    .sync_out (cmp_sync)
  );

  cmpsvd_sync u_det_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in (detector_low_out),
    .sync_out (det_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Result latches
  // comparator follows while powered, freezes when off; detector captures only at switch-off
  cmpsvd_latch u_cmp_latch (
    .aclk    (aclk),
    .aresetn (aresetn),
    .follow  (ctrl.comparator_power_on),
    .capture (1'b0),
    .d       (cmp_sync),
    .q       (cmp_result)
  );

  cmpsvd_latch u_det_latch (
    .aclk    (aclk),
    .aresetn (aresetn),
    .follow  (1'b0),
    .capture (det_capture),
    .d       (det_sync),
    .q       (low_v_result)
  );

  assign stat = {cmp_result, low_v_result};

  ////////////////////////////////////////////////////////////////////////////
  // Write channel
  assign wr_fire = aw_held && w_held && !bvalid;

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_ctrl    = ctrl;
    det_capture  = 1'b0;
    if (!aw_held && s_axi_awvalid) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (!w_held && s_axi_wvalid) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = RESP_OKAY;
      case (aw_addr)
        DETECT_THRESHOLD_SELECT_ADDR: begin
          if (w_strb[0]) begin
            next_ctrl.threshold_select = w_data[THR_LSB +: THR_W];
          end
        end
        COMPARATOR_DETECTOR_CONTROL_ADDR: begin
          if (w_strb[0]) begin
            next_ctrl.comparator_power_on = w_data[CMP_PWR_BIT];
            next_ctrl.detector_enable = w_data[DET_EN_BIT];
            det_capture = ctrl.detector_enable && !w_data[DET_EN_BIT];
          end
        end
        default: begin
          next_bresp = RESP_SLVERR;
        end
      endcase
    end
    next_aw_ready = !next_aw_held;
    next_w_ready  = !next_w_held;
  end

  always_comb begin
    next_sense_sel = EXT_SENSE && (next_ctrl.threshold_select == THR_RESET);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel
  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (!rvalid && s_axi_arvalid) begin
      next_rvalid = 1'b1;
      next_rdata  = '0;
      next_rresp  = RESP_OKAY;
      case (s_axi_araddr)
        DETECT_THRESHOLD_SELECT_ADDR: begin
          next_rdata[THR_LSB +: THR_W] = ctrl.threshold_select;
        end
        COMPARATOR_DETECTOR_CONTROL_ADDR: begin
          next_rdata[CMP_PWR_BIT] = ctrl.comparator_power_on;
          next_rdata[CMP_RES_BIT] = stat.comparator_result;
          next_rdata[LOW_V_BIT]   = stat.low_voltage_result;
          next_rdata[DET_EN_BIT]  = ctrl.detector_enable;
        end
        default: begin
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
    next_ar_ready = !next_rvalid;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl.comparator_power_on <= CMP_PWR_RESET;
      ctrl.detector_enable     <= DET_EN_RESET;
      ctrl.threshold_select    <= THR_RESET;
      sense_sel <= EXT_SENSE;
      aw_ready  <= 1'b1;
      w_ready   <= 1'b1;
      ar_ready  <= 1'b1;
      aw_held   <= 1'b0;
      aw_addr   <= '0;
      w_held    <= 1'b0;
      w_data    <= '0;
      w_strb    <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= RESP_OKAY;
      rvalid    <= 1'b0;
      rdata     <= '0;
      rresp     <= RESP_OKAY;
    end else begin
      ctrl      <= next_ctrl;
      sense_sel <= next_sense_sel;
      aw_ready  <= next_aw_ready;
      w_ready   <= next_w_ready;
      ar_ready  <= next_ar_ready;
      aw_held   <= next_aw_held;
      aw_addr   <= next_aw_addr;
      w_held    <= next_w_held;
      w_data    <= next_w_data;
      w_strb    <= next_w_strb;
      bvalid    <= next_bvalid;
      bresp     <= next_bresp;
      rvalid    <= next_rvalid;
      rdata     <= next_rdata;
      rresp     <= next_rresp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign s_axi_awready       = aw_ready;
  assign s_axi_wready        = w_ready;
  assign s_axi_bvalid        = bvalid;
  assign s_axi_bresp         = bresp;
  assign s_axi_arready       = ar_ready;
  assign s_axi_rvalid        = rvalid;
  assign s_axi_rdata         = rdata;
  assign s_axi_rresp         = rresp;
  assign comparator_power_on = ctrl.comparator_power_on;
  assign detector_enable     = ctrl.detector_enable;
  assign threshold_select    = ctrl.threshold_select;
  assign sense_pin_select    = sense_sel;

endmodule
`default_nettype wire

// ===== cmpsvd_ctrl_sva.sv
/*
  Port checker for cmpsvd_ctrl: register bus and control outputs.
  Assumes it is bound to every cmpsvd_ctrl instance below.
*/
`timescale 1ns/1ps
`default_nettype none
module cmpsvd_ctrl_sva
  import cmpsvd_pkg::*;
#(
  parameter bit EXT_SENSE = 1'b0
)
(
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_arready,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic              comparator_power_on,
  input wire logic              detector_enable,
  input wire logic [2:0]        threshold_select,
  input wire logic              sense_pin_select
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////
  // control outputs change by write; sense select and bus hold checks
  chk_power_write: assert property ($changed(comparator_power_on) |-> $rose(s_axi_bvalid))
    else $error("power bit changed without a write");
  chk_enable_write: assert property ($changed(detector_enable) |-> $rose(s_axi_bvalid))
    else $error("enable bit changed without a write");
  chk_det_off: assert property ($fell(detector_enable) |-> $rose(s_axi_bvalid) && s_axi_bresp == RESP_OKAY)
    else $error("detector off without a write");
  chk_thr_write: assert property ($changed(threshold_select) |-> $rose(s_axi_bvalid))
    else $error("threshold changed without a write");
  chk_sense_sel: assert property (sense_pin_select == (EXT_SENSE && threshold_select == 3'h0))
    else $error("sense select wrong");
  chk_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[DATA_W-1:4] == '0)
    else $error("read data upper bits set");
  chk_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
  chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer pending");
  cov_write: cover property ($rose(s_axi_bvalid));
  cov_det_off: cover property ($fell(detector_enable));
  cov_sense_on: cover property ($rose(sense_pin_select));
endmodule
bind cmpsvd_ctrl cmpsvd_ctrl_sva #(.EXT_SENSE(EXT_SENSE)) i_chk (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .comparator_power_on,
  .detector_enable, .threshold_select, .sense_pin_select);
`default_nettype wire

// ===== cmpsvd_latch.sv
/*
  Result latch with a follow enable and a one-cycle capture strobe.
  Assumes synchronous inputs; reset clears the held value.
*/
`timescale 1ns/1ps
`default_nettype none
module cmpsvd_latch
  import cmpsvd_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic follow,
  input  wire logic capture,
  input  wire logic d,
  output var  logic q
);

  logic held;
  logic next_held;

  always_comb begin
    next_held = held;
    if (follow || capture) begin
      next_held = d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      held <= 1'b0;
    end else begin
      held <= next_held;
    end
  end

  assign q = held;

endmodule
`default_nettype wire

// ===== cmpsvd_pkg.sv
/*
  Package for the comparator and supply detect control block: register map,
  field positions, reset values, timing constants and carrier structs.
  Assumes an AXI4-Lite slave with 32-bit data and a 10 MHz system clock.
*/
package cmpsvd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus and register map
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;
  localparam logic [ADDR_W-1:0] DETECT_THRESHOLD_SELECT_IDX     = 16'hFF04;
  localparam logic [ADDR_W-1:0] COMPARATOR_DETECTOR_CONTROL_IDX = 16'hFF05;
  localparam logic [17:0] DETECT_THRESHOLD_SELECT_ADDR     = {DETECT_THRESHOLD_SELECT_IDX, 2'b00};
  localparam logic [17:0] COMPARATOR_DETECTOR_CONTROL_ADDR = {COMPARATOR_DETECTOR_CONTROL_IDX, 2'b00};
  localparam int unsigned BUS_ADDR_W = 18;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int unsigned THR_LSB    = 0;
  localparam int unsigned THR_W      = 3;
  localparam int unsigned DET_EN_BIT = 0;
  localparam int unsigned LOW_V_BIT  = 1;
  localparam int unsigned CMP_RES_BIT = 2;
  localparam int unsigned CMP_PWR_BIT = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [2:0] THR_RESET     = 3'h0;
  localparam logic       CMP_PWR_RESET = 1'b0;
  localparam logic       CMP_RES_RESET = 1'b0;
  localparam logic       DET_EN_RESET  = 1'b0;
  localparam logic       LOW_V_RESET   = 1'b0;
  localparam logic [1:0] SYNC_RESET    = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Timing (software side waits, kept for reference by firmware and tests)
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned CMP_SETTLE_US   = 3000;
  localparam int unsigned DET_MIN_ON_US   = 500;
  localparam int unsigned CMP_SETTLE_CYC  = CMP_SETTLE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DET_MIN_ON_CYC  = DET_MIN_ON_US * (CLK_HZ / 1_000_000);

  ////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic       comparator_power_on;
    logic       detector_enable;
    logic [2:0] threshold_select;
  } cmpsvd_ctrl_t;

  typedef struct packed {
    logic comparator_result;
    logic low_voltage_result;
  } cmpsvd_stat_t;

endpackage

// ===== cmpsvd_sync.sv
/*
  Two-stage synchroniser for one level from the analog side.
  Assumes the input is an asynchronous level; only stage two is read.
*/
`timescale 1ns/1ps
`default_nettype none
module cmpsvd_sync
  import cmpsvd_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic async_in,
  output var  logic sync_out
);

  logic [1:0] stages;
  logic [1:0] next_stages;

  always_comb begin
    next_stages = {stages[0], async_in};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stages <= SYNC_RESET;
    end else begin
      stages <= next_stages;
    end
  end

  assign sync_out = stages[1];

endmodule
`default_nettype wire

// ===== testbench.sv
/*
  Self-checking bench for cmpsvd_ctrl over AXI4-Lite.
  Assumes the checker file is compiled alongside.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
  import cmpsvd_pkg::*;
;
  localparam logic [17:0] A_T = DETECT_THRESHOLD_SELECT_ADDR;
  localparam logic [17:0] A_C = COMPARATOR_DETECTOR_CONTROL_ADDR;
  logic                  aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic                  s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic                  s_axi_rvalid, comparator_out, detector_low_out, comparator_power_on;
  logic                  detector_enable, sense_pin_select;
  logic [1:0]            s_axi_bresp, s_axi_rresp;
  logic [BUS_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0]     s_axi_wdata, s_axi_rdata;
  logic [3:0]            s_axi_wstrb;
  logic [2:0]            s_axi_awprot, s_axi_arprot, threshold_select, code;
  logic [33:0]           e;
  logic [33:0]           rq[$];
  logic [1:0]            bq[$];
  int                    mismatches, checked;

  cmpsvd_ctrl #(.EXT_SENSE(1'b1)) i_dut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
    .s_axi_awprot, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .s_axi_rresp, .comparator_out, .detector_low_out, .comparator_power_on, .detector_enable,
    .threshold_select, .sense_pin_select);

  always #50 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  function automatic logic [33:0] ok(input logic [3:0] v);
    return {RESP_OKAY, 28'h0, v};
  endfunction

  task automatic pc(input logic [4:0] x);
    check("ports", {29'h0, comparator_power_on, detector_enable, threshold_select}, {29'h0, x});
  endtask

  task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] r);
    bq.push_back(r);
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr  <= a;
    s_axi_wvalid  <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [17:0] a, input logic [33:0] x);
    rq.push_back(x);
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr  <= a;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) check("bresp", {32'h0, s_axi_bresp}, {32'h0, bq.pop_front()});
    if (s_axi_rvalid && s_axi_rready) begin
      e = rq.pop_front();
      if (e[33:32] === RESP_OKAY) check("rdata", {s_axi_rresp, s_axi_rdata}, e);
      else check("rresp", {32'h0, s_axi_rresp}, {32'h0, e[33:32]});
    end
  end

  initial begin
    repeat (60000) @(posedge aclk);
    mismatches++;
    test_done();
  end

  initial begin
    {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, s_axi_awprot, s_axi_arprot} = '0;
    comparator_out = 1'b1;
    detector_low_out = 1'b0;
    void'($urandom(57));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_C, ok(4'h0));
    pc(5'h0);
    for (int i = 0; i < 8; i++) begin
      code = i[2:0];
      wr(A_T, {28'h0, 1'($urandom()), code}, 4'hF, RESP_OKAY);
      rd(A_T, ok({1'b0, code}));
      pc({2'b00, code});
      check("sense", {33'h0, sense_pin_select}, {33'h0, code == 3'h0});
    end
    wr(A_C, 32'h6, 4'hF, RESP_OKAY);
    wr(A_C, 32'h8, 4'h0, RESP_OKAY);
    rd(A_C, ok(4'h0));
    wr(A_C, 32'h8, 4'hF, RESP_OKAY);
    repeat (CMP_SETTLE_CYC) @(posedge aclk);
    rd(A_C, ok(4'hC));
    pc(5'h17);
    comparator_out <= 1'b0;
    repeat (5) @(posedge aclk);
    rd(A_C, ok(4'h8));
    comparator_out <= 1'b1;
    repeat (5) @(posedge aclk);
    wr(A_C, 32'h0, 4'hF, RESP_OKAY);
    comparator_out <= 1'b0;
    repeat (5) @(posedge aclk);
    rd(A_C, ok(4'h4));
    for (int j = 0; j < 2; j++) begin
      detector_low_out <= ~j[0];
      wr(A_C, 32'h1, 4'hF, RESP_OKAY);
      rd(A_C, ok({2'b01, j[0], 1'b1}));
      pc(5'h0F);
      repeat (DET_MIN_ON_CYC) @(posedge aclk);
      wr(A_C, 32'h0, 4'hF, RESP_OKAY);
      pc(5'h07);
      detector_low_out <= j[0];
      repeat (5) @(posedge aclk);
      wr(A_C, 32'h0, 4'hF, RESP_OKAY);
      rd(A_C, ok({2'b01, ~j[0], 1'b0}));
    end
    wr(18'h0, 32'h8, 4'hF, RESP_SLVERR);
    rd(18'h0, {RESP_SLVERR, 32'h0});
    rd(A_C, ok(4'h4));
    wr(A_T, 32'h5, 4'hF, RESP_OKAY);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_T, ok(4'h0));
    rd(A_C, ok(4'h0));
    pc(5'h0);
    check("sense", {33'h0, sense_pin_select}, {33'h0, 1'b1});
    test_done();
  end
endmodule
`default_nettype wire
